/* File: src/pusc_pkg.sv */
package pusc_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    PUSC_QUIET   = 3'b000,
    PUSC_INIT    = 3'b001,
    PUSC_ERASED  = 3'b010,
    PUSC_USER    = 3'b011,
    PUSC_PROGRAM = 3'b100
  } pusc_state_e;

  // Pin-cell and core enables presented to the device fabric
  typedef struct packed {
    logic outEnable;
    logic pullUpOn;
    logic inputEnable;
    logic clockEnable;
    logic blockEnable;
    logic testPortEnable;
  } pusc_ctrl_s;

  // Core clock rate and initialisation time
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned INIT_US_SMALL = 100;
  localparam int unsigned INIT_US_MID   = 200;
  localparam int unsigned INIT_US_LARGE = 300;
  localparam int unsigned INIT_CYCLES_SMALL = (INIT_US_SMALL * (CLK_HZ / 1_000_000));
  localparam int unsigned INIT_CYCLES_MID   = (INIT_US_MID * (CLK_HZ / 1_000_000));
  localparam int unsigned INIT_CYCLES_LARGE = (INIT_US_LARGE * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W = 16;

  // Quiescent, erased and user control values
  localparam pusc_ctrl_s CTRL_QUIET  = '{outEnable: 1'b0, pullUpOn: 1'b1, inputEnable: 1'b0,
                                        clockEnable: 1'b0, blockEnable: 1'b0, testPortEnable: 1'b0};
  localparam pusc_ctrl_s CTRL_ERASED = '{outEnable: 1'b0, pullUpOn: 1'b1, inputEnable: 1'b0,
                                        clockEnable: 1'b0, blockEnable: 1'b0, testPortEnable: 1'b1};
  localparam pusc_ctrl_s CTRL_USER   = '{outEnable: 1'b1, pullUpOn: 1'b0, inputEnable: 1'b1,
                                        clockEnable: 1'b1, blockEnable: 1'b1, testPortEnable: 1'b1};

endpackage : pusc_pkg

/* File: src/pusc_power_up_state_control.sv */
`timescale 1ns/10ps
`default_nettype none

module pusc_power_up_state_control #(
  parameter int unsigned INIT_CYCLES = pusc_pkg::INIT_CYCLES_SMALL
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // Supply monitor and stored configuration (asynchronous)
  input  wire logic               coreSupplyGood,
  input  wire logic               patternValid,
  input  wire logic               programMode,
  // Fabric controls
  output pusc_pkg::pusc_ctrl_s    ctrl,
  output logic                    userRegInit,
  output pusc_pkg::pusc_state_e   state
);

  // Last count of the initialisation interval, cut to the counter width
  localparam int unsigned                INIT_LAST_I = INIT_CYCLES - 1;
  localparam logic [pusc_pkg::CNT_W-1:0] INIT_LAST   = INIT_LAST_I[pusc_pkg::CNT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  logic [2:0] syncIn;
  logic       supplySafe;
  logic       patValidS;
  logic       progModeS;

  // Supply, flag and mode are level pins from outside the clock domain.
  // Each passes its own two flops; a cycle of skew between them is harmless
  // since every decision waits on settled levels.
  pusc_sync #(.WIDTH(3)) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .asyncIn  ({coreSupplyGood, patternValid, programMode}),
    .syncOut  (syncIn)
  );

  assign supplySafe = syncIn[2];
  assign patValidS  = syncIn[1];
  assign progModeS  = syncIn[0];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  pusc_pkg::pusc_state_e         state_r;
  pusc_pkg::pusc_state_e         state_nxt;
  logic [pusc_pkg::CNT_W-1:0]    initCnt_r;
  logic                          initDone;

  assign initDone = (initCnt_r == INIT_LAST);

  // Next-state decision
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pusc_pkg::PUSC_QUIET: begin
        if (supplySafe) begin
          state_nxt = pusc_pkg::PUSC_INIT;
        end
      end
      pusc_pkg::PUSC_INIT: begin
        if (initDone) begin
          state_nxt = patValidS ? pusc_pkg::PUSC_USER : pusc_pkg::PUSC_ERASED;
        end
      end
      pusc_pkg::PUSC_ERASED: begin
        if (progModeS) begin
          state_nxt = pusc_pkg::PUSC_PROGRAM;
        end
      end
      pusc_pkg::PUSC_USER: begin
        if (progModeS) begin
          state_nxt = pusc_pkg::PUSC_PROGRAM;
        end
      end
      pusc_pkg::PUSC_PROGRAM: begin
        if (!progModeS) begin
          state_nxt = pusc_pkg::PUSC_INIT;  // Re-initialise after programming
        end
      end
      default: state_nxt = pusc_pkg::PUSC_QUIET;
    endcase
    if (!supplySafe) begin
      state_nxt = pusc_pkg::PUSC_QUIET;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= pusc_pkg::PUSC_QUIET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Initialisation timer
  // Holds at the last count until the state moves on, cleared outside init
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      initCnt_r <= '0;
    end else if (state_r == pusc_pkg::PUSC_INIT && !initDone) begin
      initCnt_r <= initCnt_r + 1'b1;
    end else if (state_r != pusc_pkg::PUSC_INIT) begin
      initCnt_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  // Driven from the next state, so pins and state change on one edge and
  // never disagree for a cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl        <= pusc_pkg::CTRL_QUIET;
      userRegInit <= 1'b0;
    end else begin
      userRegInit <= (state_nxt == pusc_pkg::PUSC_INIT);
      case (state_nxt)
        pusc_pkg::PUSC_USER:    ctrl <= pusc_pkg::CTRL_USER;
        pusc_pkg::PUSC_ERASED:  ctrl <= pusc_pkg::CTRL_ERASED;
        pusc_pkg::PUSC_PROGRAM: ctrl <= pusc_pkg::CTRL_ERASED;
        default:                ctrl <= pusc_pkg::CTRL_QUIET;
      endcase
    end
  end

  assign state = state_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Checker-side count of cycles spent initialising
  logic [pusc_pkg::CNT_W-1:0] initLen_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      initLen_r <= '0;
    end else if (state_r != pusc_pkg::PUSC_INIT) begin
      initLen_r <= '0;
    end else if (initLen_r != '1) begin
      initLen_r <= initLen_r + 1'b1;
    end
  end

  // Quiescent while the supply is unsafe
  a_quiet_until_safe: assert property (@(posedge core_clk) disable iff (!rst_b)
    !supplySafe |=> state_r == pusc_pkg::PUSC_QUIET) else $error("left quiet without safe supply");

  // Pins and test port off when quiescent
  a_quiet_pins_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_QUIET |-> ctrl == pusc_pkg::CTRL_QUIET) else $error("quiet pins not off");

  // Full interval before leaving initialisation
  a_init_duration: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_INIT &&
    (state_nxt == pusc_pkg::PUSC_USER || state_nxt == pusc_pkg::PUSC_ERASED) |->
    initLen_r == INIT_LAST) else $error("init interval wrong");

  // No early exit from initialisation
  a_init_no_early: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_INIT && !initDone && supplySafe |=> state_r == pusc_pkg::PUSC_INIT)
    else $error("init ended early");

  // Init strobe tracks the initialising state
  a_init_strobe: assert property (@(posedge core_clk) disable iff (!rst_b)
    userRegInit == (state_r == pusc_pkg::PUSC_INIT)) else $error("init strobe wrong");

  // Erased device pins
  a_erased_outputs: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_ERASED |-> !ctrl.outEnable && ctrl.pullUpOn && ctrl.testPortEnable)
    else $error("erased pins wrong");

  // User operation pins
  a_user_outputs: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_USER |-> ctrl.outEnable && !ctrl.pullUpOn && ctrl.testPortEnable)
    else $error("user pins wrong");

  // Core enables only in user operation
  a_core_gated: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ctrl.inputEnable || ctrl.clockEnable || ctrl.blockEnable) |-> state_r == pusc_pkg::PUSC_USER)
    else $error("core enabled outside user");

  // Core fully enabled in user operation
  a_user_core_on: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_USER |-> ctrl.inputEnable && ctrl.clockEnable && ctrl.blockEnable)
    else $error("core not enabled in user");

  // Pull-ups on outside normal operation
  a_pullup_rule: assert property (@(posedge core_clk) disable iff (!rst_b)
    ctrl.pullUpOn == (state_r != pusc_pkg::PUSC_USER)) else $error("pull-up state wrong");

  // Programming keeps pins off, pull-ups and test port on
  a_program_pins: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_PROGRAM |-> ctrl == pusc_pkg::CTRL_ERASED)
    else $error("program pins wrong");

  // Choice after initialisation follows the stored flag
  a_choice_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_INIT && initDone && supplySafe |=>
    state_r == ($past(patValidS) ? pusc_pkg::PUSC_USER : pusc_pkg::PUSC_ERASED))
    else $error("wrong post-init choice");

  // Main scenarios
  c_reach_user:   cover property (@(posedge core_clk) disable iff (!rst_b) state_r == pusc_pkg::PUSC_USER);
  c_reach_erased: cover property (@(posedge core_clk) disable iff (!rst_b) state_r == pusc_pkg::PUSC_ERASED);
  c_brownout:     cover property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_USER ##1 state_r == pusc_pkg::PUSC_QUIET);
  c_init_abort:   cover property (@(posedge core_clk) disable iff (!rst_b)
    state_r == pusc_pkg::PUSC_INIT ##1 state_r == pusc_pkg::PUSC_QUIET);
  c_program:      cover property (@(posedge core_clk) disable iff (!rst_b) state_r == pusc_pkg::PUSC_PROGRAM);

endmodule : pusc_power_up_state_control

`default_nettype wire

/* File: src/pusc_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module pusc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  // Two-flop synchroniser per bit
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          stage1_r[gi] <= 1'b0;
          syncOut[gi]  <= 1'b0;
        end else begin
          stage1_r[gi] <= asyncIn[gi];
          syncOut[gi]  <= stage1_r[gi];
        end
      end
    end
  endgenerate

endmodule : pusc_sync

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int unsigned INIT_N = 8;
  logic                  core_clk       = 1'b0;
  logic                  rst_b          = 1'b0;
  logic                  coreSupplyGood = 1'b0;
  logic                  patternValid   = 1'b0;
  logic                  programMode    = 1'b0;
  pusc_pkg::pusc_ctrl_s  ctrl;
  logic                  userRegInit;
  pusc_pkg::pusc_state_e state;
  int                    n_errors = 0;
  int                    samples_checked = 0;
  int                    n;

  ////////////////////////////////////////////////////////////////////////
  // Clock and device under test
  always #50 core_clk = ~core_clk;

  pusc_power_up_state_control #(.INIT_CYCLES(INIT_N)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .coreSupplyGood(coreSupplyGood),
    .patternValid(patternValid), .programMode(programMode),
    .ctrl(ctrl), .userRegInit(userRegInit), .state(state));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and compares
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic fail(input string msg);
    n_errors++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask : fail

  task automatic cmpState(input pusc_pkg::pusc_state_e exp);
    samples_checked++;
    if (state !== exp) fail($sformatf("state %0d exp %0d", state, exp));
  endtask : cmpState

  task automatic cmpCtrl(input pusc_pkg::pusc_ctrl_s exp);
    samples_checked++;
    if (ctrl !== exp) fail($sformatf("ctrl %b exp %b", ctrl, exp));
  endtask : cmpCtrl

  task automatic cmpBit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) fail(msg);
  endtask : cmpBit

  // Bounded wait for a state, sampled at falling edges
  task automatic waitState(input pusc_pkg::pusc_state_e tgt, input int bound);
    n = 0;
    while (n < bound) begin
      @(negedge core_clk);
      n++;
      if (state === tgt) return;
    end
    fail("state wait timed out");
    stop_test();
  endtask : waitState

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic testQuiet;
    repeat (20) begin
      @(negedge core_clk);
      cmpState(pusc_pkg::PUSC_QUIET);
      cmpCtrl(pusc_pkg::CTRL_QUIET);
      cmpBit(userRegInit, 1'b0, "init while quiet");
    end
    $display("test quiet done");
  endtask : testQuiet

  task automatic testPowerUp(input logic pv, input pusc_pkg::pusc_state_e es, input pusc_pkg::pusc_ctrl_s ec);
    patternValid   = pv;
    coreSupplyGood = 1'b1;
    waitState(pusc_pkg::PUSC_INIT, 6);
    cmpBit(userRegInit, 1'b1, "no init");
    cmpBit(ctrl.outEnable | ctrl.inputEnable | ctrl.blockEnable, 1'b0, "enabled in init");
    waitState(es, INIT_N + 4);
    cmpBit(n >= INIT_N && n <= INIT_N + 1, 1'b1, "init length");
    cmpCtrl(ec);
    cmpBit(userRegInit, 1'b0, "init stuck");
    repeat (10) @(negedge core_clk);
    cmpState(es);
    $display("test power-up done");
  endtask : testPowerUp

  task automatic testSupplyLoss(input int inInit);
    if (inInit > 0) begin
      coreSupplyGood = 1'b1;
      waitState(pusc_pkg::PUSC_INIT, 6);
      repeat (3) @(negedge core_clk);
    end
    coreSupplyGood = 1'b0;
    waitState(pusc_pkg::PUSC_QUIET, 5);
    @(negedge core_clk);
    cmpCtrl(pusc_pkg::CTRL_QUIET);
    cmpBit(userRegInit, 1'b0, "init after loss");
    $display("test supply loss done");
  endtask : testSupplyLoss

  task automatic testProgram(input pusc_pkg::pusc_state_e es, input pusc_pkg::pusc_ctrl_s ec);
    programMode = 1'b1;
    waitState(pusc_pkg::PUSC_PROGRAM, 5);
    @(negedge core_clk);
    cmpCtrl(pusc_pkg::CTRL_ERASED);
    programMode = 1'b0;
    waitState(pusc_pkg::PUSC_INIT, 5);
    waitState(es, INIT_N + 4);
    cmpBit(n >= INIT_N && n <= INIT_N + 1, 1'b1, "re-init length");
    cmpCtrl(ec);
    $display("test program done");
  endtask : testProgram

  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (12) @(negedge core_clk);
    cmpCtrl(pusc_pkg::CTRL_QUIET);
    rst_b = 1'b1;
    testQuiet();
    testPowerUp(1'b0, pusc_pkg::PUSC_ERASED, pusc_pkg::CTRL_ERASED);
    testProgram(pusc_pkg::PUSC_ERASED, pusc_pkg::CTRL_ERASED);
    testSupplyLoss(0);
    testSupplyLoss(1);
    testPowerUp(1'b1, pusc_pkg::PUSC_USER, pusc_pkg::CTRL_USER);
    testProgram(pusc_pkg::PUSC_USER, pusc_pkg::CTRL_USER);
    testSupplyLoss(0);
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    fail("watchdog");
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
